// ---- src/toc_timer16_output_compare.sv ----
// Purpose: Counter, three output compare channels and waveform pins of a 16-bit timer
// Assumes: i_timer_tick is a one-cycle prescaled timer clock strobe from logic on i_sys_clk
// Notes: Capture register is not present, so modes topped by it count to MAX
// Summary of operation
// - Compare all 16 bits, flag on match
// - Flag with enable requests irq, ack clears
// - Writing one clears flag, zero ignored
// - Channel A value can be counter top
// - Buffered in PWM modes, not normal/CLEAR_ON_MATCH_MODE
// - Buffer loads active only at top/bottom
// - CPU reaches buffer or active per mode
// - Only CPU changes compare; high read direct
// - High byte to latch, low loads all
// - Force updates output outside PWM, no flag, no clear
// - Count write blocks next tick's match
// - Output bit kept across mode change
// - Action select unbuffered, applies next match
// - Nonzero action routes output bit to pin
// - Reset clears every output bit
// - Action zero leaves output bit alone
// - Action select never touches capture logic
// - Normal mode counts up, wraps to zero
// - Normal overflow flag set on wrap only
// - Normal mode accepts count writes anytime
// - Three independent channels A, B, C
// - Buffered A loads at top, or at bottom in frequency-correct modes
// - Count write beats clear and count
`timescale 1ns/1ps
module toc_timer16_output_compare
  import toc_pkg::*;
#(
  parameter int NUM_CH = 3
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_timer_tick,
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic [NUM_CH:0] i_irq_ack,
  output logic [NUM_CH-1:0] o_compare_irq,
  output logic o_overflow_irq,
  output logic [NUM_CH-1:0] o_pin_out,
  output logic [NUM_CH-1:0] o_pin_oe
);
  // ==========================================================
  // Mode decoding helpers
  function automatic logic is_pwm(input logic [3:0] w);
    is_pwm = !(w == WAVE_NORMAL || w == WAVE_CTC_A || w == WAVE_CTC_CAP || w == WAVE_RSVD);
  endfunction
  function automatic logic is_dual(input logic [3:0] w);
    is_dual = (w >= WAVE_PC8 && w <= WAVE_PC10) || (w >= WAVE_PFC_CAP && w <= WAVE_PC_A);
  endfunction
  function automatic logic [15:0] top_of(input logic [3:0] w, input logic [15:0] cmp_a);
    case (w)
      WAVE_PC8, WAVE_FAST8: top_of = TOP_8BIT;
      WAVE_PC9, WAVE_FAST9: top_of = TOP_9BIT;
      WAVE_PC10, WAVE_FAST10: top_of = TOP_10BIT;
      WAVE_CTC_A, WAVE_PFC_A, WAVE_PC_A, WAVE_FAST_A: top_of = cmp_a;
      default: top_of = COUNT_MAX;
    endcase
  endfunction
  function automatic logic act_next(input logic [1:0] a, input logic cur);
    case (a)
      ACT_TOGGLE: act_next = !cur;
      ACT_CLEAR: act_next = 1'b0;
      ACT_SET: act_next = 1'b1;
      default: act_next = cur;
    endcase
  endfunction

  // ==========================================================
  // AHB-Lite slave front end
  toc_bus_state_t bus_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  logic addr_ok;
  logic wr_now;
  logic [7:0] wbyte;
  logic [31:0] rd_mux;

  toc_ctrl_t ctrl_q;
  logic [NUM_CH:0] flags_q;
  logic [NUM_CH:0] irq_en_q;
  logic [15:0] count_q;
  logic down_q;
  logic [7:0] temp_q;
  logic block_q;
  logic [15:0] buf_q [NUM_CH];
  logic [15:0] act_q [NUM_CH];
  logic [NUM_CH-1:0] wave_q;
  logic [NUM_CH-1:0] dir_q;
  logic [NUM_CH-1:0] port_q;

  // Transfer accepted in the address phase
  assign addr_ok = i_hsel && i_htrans[1] && i_hready;
  assign wr_now = wr_q;
  assign wbyte = i_hwdata[7:0];
  // Writes finish with zero wait; reads take one wait so a preceding write is visible
  assign o_hreadyout = (bus_q != BUS_RD_WAIT);
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_q;

  // Address capture and read wait state
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      bus_q <= BUS_IDLE;
      wr_q <= 1'b0;
      addr_q <= BYTE_ZERO;
    end else begin
      wr_q <= addr_ok && i_hwrite;
      if (addr_ok) begin
        addr_q <= i_haddr;
      end
      case (bus_q)
        BUS_IDLE: bus_q <= (addr_ok && !i_hwrite) ? BUS_RD_WAIT : BUS_IDLE;
        BUS_RD_WAIT: bus_q <= BUS_IDLE;
        default: bus_q <= BUS_IDLE;
      endcase
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_mux = WORD_ZERO;
    case (addr_q)
      OFS_CTRL: rd_mux = {22'h000000, ctrl_q};
      OFS_FLAGS: rd_mux = {28'h0000000, flags_q};
      OFS_IRQ_EN: rd_mux = {28'h0000000, irq_en_q};
      OFS_COUNT_LOW: rd_mux = {24'h000000, count_q[7:0]};
      OFS_COUNT_HIGH: rd_mux = {24'h000000, temp_q};
      OFS_PIN: rd_mux = {26'h0000000, port_q, dir_q};
      default: begin
        for (int i = 0; i < NUM_CH; i++) begin
          // Compare reads bypass the shared latch; buffered view in PWM modes, active value otherwise
          if (addr_q == OFS_CMP_A_LOW + 8'(i * 8)) begin
            rd_mux = {24'h000000, (is_pwm(ctrl_q.waveform_select) ? buf_q[i][7:0] : act_q[i][7:0])};
          end
          if (addr_q == OFS_CMP_A_HIGH + 8'(i * 8)) begin
            rd_mux = {24'h000000, (is_pwm(ctrl_q.waveform_select) ? buf_q[i][15:8] : act_q[i][15:8])};
          end
        end
      end
    endcase
  end

  // Read data registered at the end of the wait state
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rdata_q <= WORD_ZERO;
    end else if (bus_q == BUS_RD_WAIT) begin
      rdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // Control, enable and pin registers
  logic cnt_wr;
  logic tick_ev;
  assign cnt_wr = wr_now && addr_q == OFS_COUNT_LOW;
  assign tick_ev = i_timer_tick && !cnt_wr; // CPU write wins over count and clear

  // Mode changes never touch the output bits held below
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ctrl_q <= '0;
      irq_en_q <= '0;
      dir_q <= '0;
      port_q <= '0;
    end else if (wr_now) begin
      if (addr_q == OFS_CTRL) begin
        ctrl_q <= i_hwdata[9:0]; // Actions unbuffered, used at the next match
      end
      if (addr_q == OFS_IRQ_EN) begin
        irq_en_q <= i_hwdata[NUM_CH:0];
      end
      if (addr_q == OFS_PIN) begin
        dir_q <= i_hwdata[NUM_CH-1:0];
        port_q <= i_hwdata[PIN_PORT0 +: NUM_CH];
      end
    end
  end

  // Shared high-byte latch: high writes fill it, count-low reads load it
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      temp_q <= BYTE_ZERO;
    end else if (wr_now && (addr_q == OFS_COUNT_HIGH || addr_q == OFS_CMP_A_HIGH ||
                            addr_q == OFS_CMP_B_HIGH || addr_q == OFS_CMP_C_HIGH)) begin
      temp_q <= wbyte;
    end else if (bus_q == BUS_RD_WAIT && addr_q == OFS_COUNT_LOW) begin
      temp_q <= count_q[15:8];
    end
  end

  // ==========================================================
  // Counter
  logic pwm;
  logic dual;
  logic [15:0] top;
  logic at_top;
  logic at_bottom;
  assign pwm = is_pwm(ctrl_q.waveform_select);
  assign dual = is_dual(ctrl_q.waveform_select);
  assign top = top_of(ctrl_q.waveform_select, act_q[0]);
  assign at_top = count_q == top;
  assign at_bottom = count_q == COUNT_BOTTOM;

  // Dual-slope modes turn at top and bottom; others restart from bottom after top
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      count_q <= COUNT_RESET;
      down_q <= 1'b0;
    end else if (cnt_wr) begin
      count_q <= {temp_q, wbyte}; // Accepted at any time
    end else if (i_timer_tick) begin
      if (!dual) begin
        down_q <= 1'b0;
        // Normal mode top is MAX, so it only ever wraps
        count_q <= (at_top && ctrl_q.waveform_select != WAVE_NORMAL) ? COUNT_BOTTOM : count_q + 16'h0001;
      end else if (!down_q) begin
        down_q <= at_top;
        count_q <= at_top ? count_q - 16'h0001 : count_q + 16'h0001;
      end else begin
        down_q <= !at_bottom;
        count_q <= at_bottom ? count_q + 16'h0001 : count_q - 16'h0001;
      end
    end
  end

  // Match blocker armed by every count write, released by the next tick
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      block_q <= 1'b0;
    end else if (cnt_wr) begin
      block_q <= 1'b1;
    end else if (i_timer_tick) begin
      block_q <= 1'b0;
    end
  end

  // ==========================================================
  // Compare channels
  logic [NUM_CH-1:0] match;
  logic [NUM_CH-1:0] force_ev;
  logic ovf_ev;
  logic load_ev;
  logic wrap_ev;
  logic [NUM_CH:0] set_ev;
  logic [NUM_CH-1:0][1:0] act_sel;

  // Equality over the whole word, only on an unblocked timer tick
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      match[i] = tick_ev && !block_q && count_q == act_q[i];
      force_ev[i] = wr_now && addr_q == OFS_FORCE && i_hwdata[i] && !pwm;
    end
  end

  // Overflow in normal/CLEAR_ON_MATCH_MODE when MAX rolls over, at top in fast PWM, at bottom in dual slope
  assign ovf_ev = tick_ev && (dual ? (down_q && at_bottom) : (pwm ? at_top : count_q == COUNT_MAX));
  // Buffer transfer point: bottom for frequency-correct modes, top otherwise
  assign load_ev = pwm && tick_ev && ((ctrl_q.waveform_select == WAVE_PFC_CAP ||
                   ctrl_q.waveform_select == WAVE_PFC_A) ? (down_q && at_bottom) : at_top);
  assign wrap_ev = tick_ev && at_top && !dual;
  assign set_ev = {match, ovf_ev}; // Overflow in bit 0, channels above it
  assign act_sel = ctrl_q[4 +: 2 * NUM_CH]; // Action field of each channel

  // Compare values change only through CPU writes and buffer transfers
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        buf_q[i] <= COUNT_RESET;
        act_q[i] <= COUNT_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_now && addr_q == OFS_CMP_A_LOW + 8'(i * 8)) begin
          buf_q[i] <= {temp_q, wbyte}; // All 16 bits in one cycle
        end
        if (wr_now && addr_q == OFS_CMP_A_LOW + 8'(i * 8) && !pwm) begin
          act_q[i] <= {temp_q, wbyte}; // Unbuffered outside PWM
        end else if (load_ev) begin
          act_q[i] <= buf_q[i];
        end
      end
    end
  end

  // Flags: hardware set wins over acknowledge and write-one clear
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      flags_q <= '0;
    end else begin
      for (int i = 0; i <= NUM_CH; i++) begin
        if (set_ev[i]) begin
          flags_q[i] <= 1'b1;
        end else if ((wr_now && addr_q == OFS_FLAGS && i_hwdata[i]) || (i_irq_ack[i] && irq_en_q[i])) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt requests are plain levels
  assign o_compare_irq = flags_q[NUM_CH:FLAG_CMP0] & irq_en_q[NUM_CH:FLAG_CMP0];
  assign o_overflow_irq = flags_q[FLAG_OVF] && irq_en_q[FLAG_OVF];

  // Waveform output bits, one per channel
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      wave_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!pwm) begin
          if (match[i] || force_ev[i]) begin
            wave_q[i] <= act_next(act_sel[i], wave_q[i]);
          end
        end else if (act_sel[i] == ACT_TOGGLE) begin
          // Toggle only exists on channel A when A sets top
          if (i == 0 && top == act_q[0] && match[i]) begin
            wave_q[i] <= !wave_q[i];
          end
        end else if (act_sel[i] != ACT_NONE) begin
          // Bottom restart has priority so a match at top gives a steady level
          if (wrap_ev) begin
            wave_q[i] <= (act_sel[i] == ACT_CLEAR);
          end else if (match[i]) begin
            wave_q[i] <= (act_sel[i] == ACT_SET) ^ (dual && down_q);
          end
        end
      end
    end
  end

  // Pin source: output bit when any action bit is set; direction still gates the driver
  // Capture logic does not exist here and the selector feeds only this path and the output-bit logic
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_pin_out <= '0;
      o_pin_oe <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        o_pin_out[i] <= (ctrl_q[4 + 2 * i +: 2] != ACT_NONE) ? wave_q[i] : port_q[i];
        o_pin_oe[i] <= dir_q[i];
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  match_flag_set_a: assert property (match[0] |=> flags_q[FLAG_CMP0])
    else $error("match did not set flag A");
  w1c_clear_a: assert property (wr_now && addr_q == OFS_FLAGS && i_hwdata[1] && !match[0] |=> !flags_q[1])
    else $error("write one did not clear flag A");
  w0_keep_a: assert property (wr_now && addr_q == OFS_FLAGS && !i_hwdata[1] && flags_q[1] &&
    !(i_irq_ack[1] && irq_en_q[1]) |=> flags_q[1])
    else $error("write zero cleared flag A");
  irq_level_a: assert property (o_compare_irq[0] && !i_irq_ack[FLAG_CMP0] &&
    !(wr_now && (addr_q == OFS_FLAGS || addr_q == OFS_IRQ_EN)) |=> o_compare_irq[0])
    else $error("irq dropped while flag and enable set");
  block_arm_a: assert property (cnt_wr |=> block_q)
    else $error("count write did not arm the blocker");
  block_match_a: assert property (block_q && tick_ev |=>
    (flags_q[NUM_CH:FLAG_CMP0] & ~$past(flags_q[NUM_CH:FLAG_CMP0])) == '0)
    else $error("match not blocked after count write");
  buf_hold_a: assert property (pwm && !load_ev && $stable(ctrl_q) |=> $stable(act_q[1]))
    else $error("active compare changed off top");
  normal_wrap_a: assert property (ctrl_q.waveform_select == WAVE_NORMAL && tick_ev && count_q == COUNT_MAX
    |=> count_q == COUNT_BOTTOM && flags_q[FLAG_OVF])
    else $error("normal mode wrap wrong");
  force_no_flag_a: assert property (force_ev[1] && !match[1] && !flags_q[2] |=> !flags_q[2])
    else $error("force set the flag");
  pin_mux_a: assert property ($past(ctrl_q.action_b) != ACT_NONE |-> o_pin_out[1] == $past(wave_q[1]))
    else $error("pin not driven from output bit");
  reset_wave_a: assert property ($rose(i_resetn) |-> wave_q == '0)
    else $error("output bits not cleared by reset");
  cnt_write_a: assert property (cnt_wr |=> count_q == {$past(temp_q), $past(wbyte)})
    else $error("count write lost");
endmodule

// ---- src/toc_pkg.sv ----
// Purpose: Shared constants and types for the 16-bit timer output compare block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: Byte-wide registers sit in the low eight bits of their word
package toc_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FORCE = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h10;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h14;
  localparam logic [7:0] OFS_CMP_A_LOW = 8'h18;
  localparam logic [7:0] OFS_CMP_A_HIGH = 8'h1C;
  localparam logic [7:0] OFS_CMP_B_LOW = 8'h20;
  localparam logic [7:0] OFS_CMP_B_HIGH = 8'h24;
  localparam logic [7:0] OFS_CMP_C_LOW = 8'h28;
  localparam logic [7:0] OFS_CMP_C_HIGH = 8'h2C;
  localparam logic [7:0] OFS_PIN = 8'h30;
  // ==========================================================
  // Field positions and reset values
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP0 = 1;
  localparam int PIN_PORT0 = 3;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // ==========================================================
  // Waveform select codes
  localparam logic [3:0] WAVE_NORMAL = 4'h0;
  localparam logic [3:0] WAVE_PC8 = 4'h1;
  localparam logic [3:0] WAVE_PC9 = 4'h2;
  localparam logic [3:0] WAVE_PC10 = 4'h3;
  localparam logic [3:0] WAVE_CTC_A = 4'h4;
  localparam logic [3:0] WAVE_FAST8 = 4'h5;
  localparam logic [3:0] WAVE_FAST9 = 4'h6;
  localparam logic [3:0] WAVE_FAST10 = 4'h7;
  localparam logic [3:0] WAVE_PFC_CAP = 4'h8;
  localparam logic [3:0] WAVE_PFC_A = 4'h9;
  localparam logic [3:0] WAVE_PC_CAP = 4'hA;
  localparam logic [3:0] WAVE_PC_A = 4'hB;
  localparam logic [3:0] WAVE_CTC_CAP = 4'hC;
  localparam logic [3:0] WAVE_RSVD = 4'hD;
  localparam logic [3:0] WAVE_FAST_CAP = 4'hE;
  localparam logic [3:0] WAVE_FAST_A = 4'hF;
  // Output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // ==========================================================
  // Control register layout, high bits first
  typedef struct packed {
    logic [1:0] action_c;
    logic [1:0] action_b;
    logic [1:0] action_a;
    logic [3:0] waveform_select;
  } toc_ctrl_t;
  typedef enum logic {BUS_IDLE, BUS_RD_WAIT} toc_bus_state_t;
endpackage

// ---- dv/toc_ahb_master.sv ----
// Purpose: AHB-Lite master standing in for the CPU on the register bus
// Assumes: single word transfers, hready is the one slave's hreadyout
// Notes: waits for hready without limit, the bench watchdog ends a hang
`timescale 1ns/1ps
module toc_ahb_master (
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [7:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    o_hsel = 1'b0;
    o_haddr = 8'h00;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0000_0000;
  end
  // One transfer, address phase held until hready, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    o_hsel <= 1'b1;
    o_haddr <= a;
    o_htrans <= 2'h2;
    o_hwrite <= w;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    o_htrans <= 2'h0;
    o_hwdata <= d;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    q = i_hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  // High byte always goes first so the low write loads all 16 bits
  task automatic wr16(input logic [7:0] ah, input logic [7:0] al, input logic [15:0] v);
    wr(ah, {24'h000000, v[15:8]});
    wr(al, {24'h000000, v[7:0]});
  endtask
endmodule

// ---- dv/tb_timer16_output_compare.sv ----
// Purpose: Self-checking bench for the timer output compare block
// Assumes: reads get one wait state, timer tick driven by the bench
// Notes: expected flags and output bit come from a small bench model
`timescale 1ns/1ps
module tb_timer16_output_compare;
  import toc_pkg::*;
  logic clk = 1'b0;
  logic i_resetn = 1'b0;
  logic tick = 1'b0;
  logic [3:0] ack = 4'h0;
  logic hsel, hwrite, hready, hresp, ovf_irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, cmp_irq, pin_out, pin_oe;
  logic [31:0] hwdata, hrdata, q, rnd;
  int num_errors = 0;
  int cmp_count = 0;
  int exp_flags = 0;
  int ob = 0;
  logic [1:0] acts[$] = '{ACT_SET, ACT_TOGGLE, ACT_CLEAR, ACT_TOGGLE, ACT_NONE};
  toc_ctrl_t ctrl;
  // ==========================================================
  // Clock, design and bus partner
  always #2.5 clk = ~clk;
  toc_timer16_output_compare #(.NUM_CH(3)) i_toc_timer16_output_compare (
    .i_sys_clk(clk), .i_resetn(i_resetn), .i_timer_tick(tick), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_irq_ack(ack), .o_compare_irq(cmp_irq),
    .o_overflow_irq(ovf_irq), .o_pin_out(pin_out), .o_pin_oe(pin_oe));
  toc_ahb_master i_toc_ahb_master (
    .i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
    .o_hwdata(hwdata));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask
  // Holding the strobe high n edges gives n timer clocks
  task automatic ticks(input int n);
    repeat (n) @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
  endtask
  task automatic flags_chk();
    i_toc_ahb_master.rd(OFS_FLAGS, q);
    chk("flags", exp_flags, q);
  endtask
  // Count write lands one below compare A so the second tick matches A
  task automatic hit_a();
    i_toc_ahb_master.wr16(OFS_COUNT_HIGH, OFS_COUNT_LOW, 16'h00FF);
    ticks(1);
    flags_chk();
    ticks(1);
    exp_flags |= 2;
    flags_chk();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog sized well above the expected run length
  initial begin
    #(5 * 20000);
    num_errors++;
    summarize();
  end
  // ==========================================================
  // Main sequence
  initial begin
    rnd = 32'h3EAB;
    repeat (20) @(posedge clk);
    i_resetn <= 1'b1;
    i_toc_ahb_master.rd(OFS_CTRL, q);
    chk("ctrl reset", WORD_ZERO, q);
    flags_chk();
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("pin reset", 32'h0, {29'h0, pin_out});
    $display("test reset done");
    // Count write equal to compare value must not match next tick
    i_toc_ahb_master.wr16(OFS_CMP_A_HIGH, OFS_CMP_A_LOW, 16'h0100);
    i_toc_ahb_master.wr16(OFS_COUNT_HIGH, OFS_COUNT_LOW, 16'h0100);
    ticks(1);
    flags_chk();
    hit_a();
    i_toc_ahb_master.wr(OFS_FLAGS, WORD_ZERO);
    flags_chk();
    i_toc_ahb_master.wr(OFS_FLAGS, 32'h2);
    exp_flags = 0;
    flags_chk();
    hit_a();
    i_toc_ahb_master.wr(OFS_IRQ_EN, 32'h2);
    @(posedge clk);
    chk("irq on", 32'h1, {29'h0, cmp_irq});
    i_toc_ahb_master.wr(OFS_IRQ_EN, WORD_ZERO);
    @(posedge clk);
    chk("irq off", 32'h0, {29'h0, cmp_irq});
    i_toc_ahb_master.wr(OFS_IRQ_EN, 32'h2);
    @(posedge clk) ack <= 4'h2;
    @(posedge clk) ack <= 4'h0;
    exp_flags = 0;
    flags_chk();
    chk("irq acked", 32'h0, {29'h0, cmp_irq});
    $display("test compare done");
    // Wrap from the maximum sets overflow and restarts at zero
    i_toc_ahb_master.wr16(OFS_COUNT_HIGH, OFS_COUNT_LOW, COUNT_MAX);
    ticks(1);
    exp_flags |= 1;
    flags_chk();
    i_toc_ahb_master.wr(OFS_IRQ_EN, 32'h3);
    @(posedge clk);
    chk("ovf irq on", 32'h1, {31'h0, ovf_irq});
    i_toc_ahb_master.rd(OFS_COUNT_LOW, q);
    chk("count wrap", 32'h0, q);
    i_toc_ahb_master.wr(OFS_FLAGS, 32'h1);
    exp_flags = 0;
    @(posedge clk);
    chk("ovf irq off", 32'h0, {31'h0, ovf_irq});
    $display("test overflow done");
    // Random compare values survive a later latch write
    repeat (4) begin
      rnd = lfsr_next(rnd);
      i_toc_ahb_master.wr16(OFS_CMP_C_HIGH, OFS_CMP_C_LOW, rnd[15:0]);
      i_toc_ahb_master.wr(OFS_COUNT_HIGH, {24'h0, rnd[23:16]});
      i_toc_ahb_master.rd(OFS_CMP_C_HIGH, q);
      chk("cmp high", {24'h0, rnd[15:8]}, q);
      i_toc_ahb_master.rd(OFS_CMP_C_LOW, q);
      chk("cmp low", {24'h0, rnd[7:0]}, q);
    end
    i_toc_ahb_master.wr(8'h3C, rnd);
    i_toc_ahb_master.rd(8'h3C, q);
    chk("unmapped", WORD_ZERO, q);
    $display("test access done");
    // Force strobe on channel B through every action code
    i_toc_ahb_master.wr(OFS_PIN, 32'h7);
    // Enable is registered one edge after the direction bits
    repeat (2) @(posedge clk);
    chk("pin oe", 32'h7, {29'h0, pin_oe});
    ctrl = '0;
    foreach (acts[i]) begin
      ctrl.action_b = acts[i];
      i_toc_ahb_master.wr(OFS_CTRL, {22'h0, ctrl});
      i_toc_ahb_master.wr(OFS_FORCE, 32'h2);
      repeat (3) @(posedge clk);
      case (acts[i])
        ACT_TOGGLE: ob = 1 - ob;
        ACT_CLEAR: ob = 0;
        ACT_SET: ob = 1;
        default: ob = ob;
      endcase
      chk("pin b", (acts[i] != ACT_NONE) ? ob : 0, {31'h0, pin_out[1]});
    end
    flags_chk();
    i_toc_ahb_master.rd(OFS_COUNT_LOW, q);
    chk("count kept", 32'h0, q);
    $display("test force done");
    // Mode change keeps the output bit, buffered compare waits for top
    ctrl.action_b = ACT_CLEAR;
    ctrl.waveform_select = WAVE_FAST8;
    i_toc_ahb_master.wr(OFS_CTRL, {22'h0, ctrl});
    repeat (3) @(posedge clk);
    chk("pin mode", ob, {31'h0, pin_out[1]});
    i_toc_ahb_master.wr16(OFS_COUNT_HIGH, OFS_COUNT_LOW, 16'h0010);
    i_toc_ahb_master.wr16(OFS_CMP_B_HIGH, OFS_CMP_B_LOW, 16'h0020);
    ticks(18);
    flags_chk();
    ticks(32'hDE + 32'h20);
    exp_flags |= 1;
    flags_chk();
    ticks(1);
    exp_flags |= 4;
    flags_chk();
    $display("test buffer done");
    // Clear on match with A as top: real match toggles A, count restarts at zero
    ctrl.action_a = ACT_TOGGLE;
    ctrl.waveform_select = WAVE_CTC_A;
    i_toc_ahb_master.wr(OFS_CTRL, {22'h0, ctrl});
    i_toc_ahb_master.wr16(OFS_CMP_A_HIGH, OFS_CMP_A_LOW, 16'h0004);
    i_toc_ahb_master.wr16(OFS_COUNT_HIGH, OFS_COUNT_LOW, COUNT_BOTTOM);
    ticks(5);
    exp_flags |= 2;
    flags_chk();
    chk("pin a", 32'h1, {31'h0, pin_out[0]});
    i_toc_ahb_master.rd(OFS_COUNT_LOW, q);
    chk("count top", 32'h0, q);
    $display("test clear on match done");
    summarize();
  end
endmodule
